// >>> rtl/sysc_pkg.sv
// constants and types of the system configuration block
`default_nettype none
package sysc_pkg;
  localparam int          ADDR_W        = 18;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_SYSCFG    = 16'hFF12;
  localparam logic [15:0] IDX_SYSCFG_SH = 16'h0089;
  localparam logic [15:0] IDX_SP        = 16'hFF20;
  localparam logic [15:0] IDX_OVF_LIM   = 16'hFF21;
  localparam logic [15:0] IDX_UNF_LIM   = 16'hFF22;
  localparam logic [15:0] IDX_CTX_PTR   = 16'hFF23;
  localparam logic [15:0] IDX_IRQEN     = 16'hFF24;
  localparam logic [15:0] IDX_STATUS    = 16'hFF25;
  // system_config fields
  localparam int          B_XBUS_SHARE  = 0;
  localparam int          B_XBUS_EN     = 2;
  localparam int          B_BDRST       = 3;
  localparam int          B_OSC_WD_DIS  = 4;
  localparam int          B_PD_CFG      = 5;
  localparam int          B_CS_CFG      = 6;
  localparam int          B_WR_CFG      = 7;
  localparam int          B_BYTE_DIS    = 9;
  localparam int          B_MEM_EN      = 10;
  localparam logic [15:0] SYSCFG_RST    = 16'h0000;
  // strap pin positions
  localparam int          S_BUSW        = 7;
  localparam int          S_WR_CFG      = 8;
  // other reset values, stack size and stack step
  localparam logic [15:0] SP_RST        = 16'hFC00;
  localparam logic [15:0] OVF_LIM_RST   = 16'hFA00;
  localparam logic [15:0] UNF_LIM_RST   = 16'hFC00;
  localparam logic [15:0] CTX_PTR_RST   = 16'hFC00;
  localparam logic [15:0] STACK_BYTES   = 16'h0400;
  localparam logic [15:0] STACK_STEP    = 16'h0002;
  // timing
  localparam int          CLK_MHZ       = 250;
  localparam int          WD_IDLE_NS    = 1000;
  localparam int          WD_IDLE_CYC   = (WD_IDLE_NS * CLK_MHZ + 999) / 1000;
  localparam int          RST_DRIVE_PH  = 1024;
  localparam int          PHASE_DIV     = 1;
  typedef struct packed {
    logic       pd_active;
    logic       clk_on_pll;
    logic       locked;
    logic       stk_under;
    logic       stk_over;
  } sysc_status_t;
endpackage
`default_nettype wire

// >>> rtl/sysc_config.sv
// system configuration register bank with stack checks and context pointer
// What this block does
// - reset value zero except bits loaded from strap pins and access pin
// - memory enable, byte disable, write config taken from straps and access pin
// - end-of-init instruction locks system_config against register writes until soft reset
// - xbus peripheral enable gates access to xbus peripherals
// - bidir reset bit clear: reset pin never driven
// - bidir reset bit set: reset pin driven low 1024 phases per soft reset
// - watchdog on, pll bypassed: 1 us idle crystal switches to pll clock
// - watchdog off, pll bypassed: crystal clock only and pll switched off
// - powerdown config 0: enter only with nmi low, leave by reset pin
// - powerdown config 1: enter when enabled irqs idle, any enabled irq exits
// - chipselect config 0: chip selects change one phase after ale rise
// - chipselect config 1: chip selects change with ale rise
// - system_config reachable by byte lanes at word address and short address
// - each push compares pointer with overflow limit and underflow limit less 1024, each pop with underflow limit
// - stack of up to 1024 bytes reached through stack pointer
// - register bank of 16 words located at context pointer
`default_nettype none
module sysc_config #(
  parameter int NUM_IRQ = 4,
  parameter int NUM_CS  = 5
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [sysc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic [15:0]                strap_port_zero,
  input  wire logic                       external_access_pin,
  input  wire logic                       reset_in_pin_n_i,
  output logic                            reset_in_pin_n_o,
  output logic                            reset_in_pin_n_oe_n,
  input  wire logic                       nmi_pin_n,
  input  wire logic [NUM_IRQ-1:0]         fast_ext_irq_pins,
  input  wire logic                       crystal_input,
  input  wire logic                       pll_bypass,
  input  wire logic                       soft_reset_req,
  input  wire logic                       end_of_init_instr,
  input  wire logic                       powerdown_instr,
  input  wire logic                       ale,
  input  wire logic [NUM_CS-1:0]          cs_decode,
  input  wire logic                       stack_push,
  input  wire logic                       stack_pop,
  input  wire logic [3:0]                 gpr_index,
  output logic      [15:0]                system_config,
  output logic                            xbus_periph_enable,
  output logic                            clk_on_pll,
  output logic                            pll_enable,
  output logic                            powerdown_active,
  output logic      [NUM_CS-1:0]          chip_select_lines,
  output logic                            stack_overflow,
  output logic                            stack_underflow,
  output logic      [15:0]                stack_pointer_reg,
  output logic      [15:0]                gpr_addr
);
  import sysc_pkg::*;

  localparam int          IDLE_W   = $clog2(WD_IDLE_CYC + 1);
  localparam int          DRV_W    = $clog2(RST_DRIVE_PH * PHASE_DIV + 1);
  localparam logic [IDLE_W-1:0] IDLE_LIM = IDLE_W'(WD_IDLE_CYC);
  localparam logic [DRV_W-1:0]  DRV_LIM  = DRV_W'(RST_DRIVE_PH * PHASE_DIV);

  // two-stage synchronisers for pins
  localparam int SYN_W = 16 + NUM_IRQ + 4;
  logic [SYN_W-1:0] syn_a;
  logic [SYN_W-1:0] syn_b;
  // no reset: straps are sampled while reset is held
  always_ff @(posedge pclk) begin
    syn_a <= {strap_port_zero, fast_ext_irq_pins, external_access_pin,
              reset_in_pin_n_i, nmi_pin_n, crystal_input};
    syn_b <= syn_a;
  end
  logic [15:0]        strap_s;
  logic [NUM_IRQ-1:0] irq_s;
  logic               ext_acc_s;
  logic               rstpin_n_s;
  logic               nmi_n_s;
  logic               xtal_s;
  assign {strap_s, irq_s, ext_acc_s, rstpin_n_s, nmi_n_s, xtal_s} = syn_b;

  // apb decode
  logic [15:0] idx;
  logic        acc;
  logic        wr;
  logic        hit_cfg;
  logic        mapped;
  assign idx     = paddr[ADDR_W-1:2];
  assign acc     = psel && penable && !pready;
  // writes land at the completing edge
  assign wr      = psel && penable && pready && pwrite;
  // short and long address alias
  // two aliases
  assign hit_cfg = (idx == IDX_SYSCFG) || (idx == IDX_SYSCFG_SH);
  assign mapped  = hit_cfg || idx == IDX_SP || idx == IDX_OVF_LIM || idx == IDX_UNF_LIM
                || idx == IDX_CTX_PTR || idx == IDX_IRQEN || idx == IDX_STATUS;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // strap capture and lock
  logic strap_pend;
  logic locked;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_pend <= 1'b1;
    end else begin
      strap_pend <= soft_reset_req;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked <= 1'b0;
    end else if (soft_reset_req) begin
      locked <= 1'b0;
    end else if (end_of_init_instr) begin
      locked <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_config <= SYSCFG_RST;
    end else if (soft_reset_req) begin
      system_config <= SYSCFG_RST;
    end else if (strap_pend) begin
      system_config[B_MEM_EN]   <= ext_acc_s;
      system_config[B_BYTE_DIS] <= strap_s[S_BUSW];
      system_config[B_WR_CFG]   <= strap_s[S_WR_CFG];
    end else if (wr && hit_cfg && !locked) begin
      system_config <= merge(system_config, pwdata, pstrb);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xbus_periph_enable <= 1'b0;
    end else begin
      xbus_periph_enable <= system_config[B_XBUS_EN];
    end
  end

  // reset pin drive on soft reset
  logic [DRV_W-1:0] drv_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv_cnt             <= '0;
      reset_in_pin_n_o    <= 1'b0;
      reset_in_pin_n_oe_n <= 1'b1;
    end else begin
      reset_in_pin_n_o <= 1'b0;
      if (soft_reset_req && system_config[B_BDRST]) begin
        // drive low for the reset sequence
        drv_cnt             <= DRV_LIM;
        reset_in_pin_n_oe_n <= 1'b0;
      end else if (drv_cnt > DRV_W'(1)) begin
        drv_cnt <= drv_cnt - DRV_W'(1);
      end else begin
        drv_cnt             <= '0;
        reset_in_pin_n_oe_n <= 1'b1;
      end
    end
  end

  // oscillator watchdog
  logic             xtal_q;
  logic [IDLE_W-1:0] idle_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_q   <= 1'b0;
      idle_cnt <= '0;
    end else begin
      xtal_q <= xtal_s;
      if (xtal_q != xtal_s || !pll_bypass) begin
        idle_cnt <= '0;
      end else if (idle_cnt != IDLE_LIM) begin
        idle_cnt <= idle_cnt + IDLE_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_on_pll <= 1'b0;
      pll_enable <= 1'b1;
    end else if (pll_bypass && system_config[B_OSC_WD_DIS]) begin
      clk_on_pll <= 1'b0;
      pll_enable <= 1'b0;
    end else begin
      pll_enable <= 1'b1;
      // idle crystal falls back to pll
      if (!pll_bypass) begin
        clk_on_pll <= 1'b1;
      end else if (idle_cnt == IDLE_LIM) begin
        clk_on_pll <= 1'b1;
      end
    end
  end

  // power down entry and exit
  logic [NUM_IRQ-1:0] irq_enable;
  logic               irq_hit;
  assign irq_hit = |(irq_s & irq_enable);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      powerdown_active <= 1'b0;
    end else if (!powerdown_active) begin
      if (powerdown_instr) begin
        powerdown_active <= system_config[B_PD_CFG] ? !irq_hit : !nmi_n_s;
      end
    end else if (system_config[B_PD_CFG] ? irq_hit : !rstpin_n_s) begin
      powerdown_active <= 1'b0;
    end
  end

  // chip select timing
  logic              ale_q;
  logic              cs_pend;
  logic [NUM_CS-1:0] cs_hold;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ale_q             <= 1'b0;
      cs_pend           <= 1'b0;
      cs_hold           <= '1;
      chip_select_lines <= '1;
    end else begin
      ale_q   <= ale;
      cs_pend <= 1'b0;
      if (ale && !ale_q) begin
        if (system_config[B_CS_CFG]) begin
          chip_select_lines <= cs_decode;
        end else begin
          cs_hold <= cs_decode;
          cs_pend <= 1'b1;
        end
      end
      if (cs_pend) begin
        chip_select_lines <= cs_hold;
      end
    end
  end

  // stack and context pointers
  logic [15:0] ovf_lim;
  logic [15:0] unf_lim;
  logic [15:0] ctx_ptr;
  logic [15:0] sp_new;
  logic        stk_acc;
  assign stk_acc = stack_push ^ stack_pop;
  // word steps over the whole 16-bit address range
  assign sp_new  = stack_push ? stack_pointer_reg - STACK_STEP : stack_pointer_reg + STACK_STEP;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_pointer_reg <= SP_RST;
    end else if (stk_acc) begin
      stack_pointer_reg <= sp_new;
    end else if (wr && idx == IDX_SP) begin
      stack_pointer_reg <= merge(stack_pointer_reg, pwdata, pstrb) & ~16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_lim    <= OVF_LIM_RST;
      unf_lim    <= UNF_LIM_RST;
      ctx_ptr    <= CTX_PTR_RST;
      irq_enable <= '0;
    end else if (wr) begin
      if (idx == IDX_OVF_LIM) begin
        ovf_lim <= merge(ovf_lim, pwdata, pstrb);
      end
      if (idx == IDX_UNF_LIM) begin
        unf_lim <= merge(unf_lim, pwdata, pstrb);
      end
      if (idx == IDX_CTX_PTR) begin
        ctx_ptr <= merge(ctx_ptr, pwdata, pstrb);
      end
      if (idx == IDX_IRQEN && pstrb[0]) begin
        irq_enable <= pwdata[NUM_IRQ-1:0];
      end
    end
  end

  // sticky stack flags, write one to clear, set wins
  logic ov_set;
  logic un_set;
  logic clr_st;
  assign ov_set = stk_acc && stack_push && (sp_new < ovf_lim
               || sp_new < unf_lim - STACK_BYTES);
  assign un_set = stk_acc && stack_pop && sp_new > unf_lim;
  assign clr_st = wr && idx == IDX_STATUS && pstrb[0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_overflow  <= 1'b0;
      stack_underflow <= 1'b0;
    end else begin
      stack_overflow  <= ov_set || (stack_overflow && !(clr_st && pwdata[0]));
      stack_underflow <= un_set || (stack_underflow && !(clr_st && pwdata[1]));
    end
  end

  // bank of 16 words at cp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpr_addr <= CTX_PTR_RST;
    end else begin
      gpr_addr <= ctx_ptr + {11'h000, gpr_index, 1'b0};
    end
  end

  // read mux and apb answer
  sysc_status_t st;
  logic [15:0]  rd;
  assign st = '{pd_active: powerdown_active, clk_on_pll: clk_on_pll, locked: locked,
                stk_under: stack_underflow, stk_over: stack_overflow};
  always_comb begin
    rd = 16'h0000;
    case (idx)
      IDX_SYSCFG, IDX_SYSCFG_SH: rd = system_config;
      IDX_SP:     rd = stack_pointer_reg;
      IDX_OVF_LIM: rd = ovf_lim;
      IDX_UNF_LIM: rd = unf_lim;
      IDX_CTX_PTR: rd = ctx_ptr;
      IDX_IRQEN:  rd = 16'(irq_enable);
      IDX_STATUS: rd = 16'(st);
      default:    rd = 16'h0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= acc;
      pslverr <= acc && !mapped;
      if (acc && !pwrite) begin
        prdata <= {16'h0000, rd};
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/sysc_config_assertions.sv
// port-level assertions for the system configuration block
`default_nettype none
module sysc_config_assertions
  import sysc_pkg::*;
#(
  parameter int NUM_IRQ = 4,
  parameter int NUM_CS  = 5
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              soft_reset_req,
  input wire logic              reset_in_pin_n_oe_n,
  input wire logic              pll_bypass,
  input wire logic              pll_enable,
  input wire logic              ale,
  input wire logic [NUM_CS-1:0] cs_decode,
  input wire logic [NUM_CS-1:0] chip_select_lines,
  input wire logic              stack_push,
  input wire logic              stack_pop,
  input wire logic [15:0]       stack_pointer_reg,
  input wire logic              powerdown_instr,
  input wire logic              nmi_pin_n,
  input wire logic              powerdown_active,
  input wire logic [15:0]       system_config,
  input wire logic              xbus_periph_enable
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence nmi_high_s;
    nmi_pin_n [*3];
  endsequence
  sequence pd_try_s;
    powerdown_instr && !system_config[B_PD_CFG] && !powerdown_active;
  endsequence
  AST_APB_ANSWER: assert property (psel && penable && !pready |=> pready)
    else $error("apb access not answered in the next cycle");
  AST_SLVERR_PAIR: assert property (pslverr |-> pready)
    else $error("slave error without ready");
  AST_XBUS_COPY: assert property (1'b1 |=> xbus_periph_enable == $past(system_config[B_XBUS_EN]))
    else $error("xbus enable does not follow its bit");
  AST_BDR_OFF: assert property (soft_reset_req && !system_config[B_BDRST] && reset_in_pin_n_oe_n
    |=> reset_in_pin_n_oe_n [*4])
    else $error("reset pin driven with bidir reset off");
  AST_BDR_ON: assert property (soft_reset_req && system_config[B_BDRST]
    |=> ##[0:2] !reset_in_pin_n_oe_n [*8])
    else $error("reset pin not driven with bidir reset on");
  AST_PLL_OFF: assert property ((pll_bypass && system_config[B_OSC_WD_DIS]) [*3] |-> !pll_enable)
    else $error("pll left on with watchdog disabled");
  AST_CS_UNLATCH: assert property ($rose(ale) && system_config[B_CS_CFG]
    |=> chip_select_lines == $past(cs_decode))
    else $error("unlatched chip selects late");
  AST_CS_LATCH: assert property ($rose(ale) && !system_config[B_CS_CFG]
    |=> ##1 chip_select_lines == $past(cs_decode, 2))
    else $error("latched chip selects wrong");
  AST_PUSH: assert property (stack_push && !stack_pop
    |=> stack_pointer_reg == $past(stack_pointer_reg) - STACK_STEP)
    else $error("push did not lower stack pointer");
  AST_POP: assert property (stack_pop && !stack_push
    |=> stack_pointer_reg == $past(stack_pointer_reg) + STACK_STEP)
    else $error("pop did not raise stack pointer");
  AST_PD_NMI: assert property (nmi_high_s ##0 pd_try_s |=> !powerdown_active)
    else $error("powerdown entered with nmi high");
endmodule
bind sysc_config sysc_config_assertions #(.NUM_IRQ(NUM_IRQ), .NUM_CS(NUM_CS)) u_chk (
  .pclk, .presetn, .psel, .penable, .pready, .pslverr, .soft_reset_req, .reset_in_pin_n_oe_n,
  .pll_bypass, .pll_enable, .ale, .cs_decode, .chip_select_lines, .stack_push, .stack_pop,
  .stack_pointer_reg, .powerdown_instr, .nmi_pin_n, .powerdown_active, .system_config,
  .xbus_periph_enable
);
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench of the system configuration block
`default_nettype none
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin n_mismatch++; $display("unexpected %s exp %h got %h", nm, e, s); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sysc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, ext_rstn, xtal_run;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  pstrb, fast_ext_irq_pins, gpr_index;
  logic [15:0] strap_port_zero, system_config, stack_pointer_reg, gpr_addr, v, sp_e;
  logic        external_access_pin, reset_in_pin_n_o, reset_in_pin_n_oe_n, nmi_pin_n, crystal_input;
  logic        pll_bypass, soft_reset_req, end_of_init_instr, powerdown_instr, ale, stack_push;
  logic        stack_pop, xbus_periph_enable, clk_on_pll, pll_enable, powerdown_active;
  logic        stack_overflow, stack_underflow;
  logic [4:0]  cs_decode, chip_select_lines, cs_old;
  logic [15:0] rst_tab [4] = '{SP_RST, OVF_LIM_RST, UNF_LIM_RST, CTX_PTR_RST};
  integer      seed;
  int          n_mismatch, checks, cnt;
  // pin level from both parties
  wire logic   rst_pin = reset_in_pin_n_oe_n ? ext_rstn : reset_in_pin_n_o;
  sysc_config #(.NUM_IRQ(4), .NUM_CS(5)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .strap_port_zero, .external_access_pin, .reset_in_pin_n_i(rst_pin), .reset_in_pin_n_o,
    .reset_in_pin_n_oe_n, .nmi_pin_n, .fast_ext_irq_pins, .crystal_input, .pll_bypass,
    .soft_reset_req, .end_of_init_instr, .powerdown_instr, .ale, .cs_decode, .stack_push,
    .stack_pop, .gpr_index, .system_config, .xbus_periph_enable, .clk_on_pll, .pll_enable,
    .powerdown_active, .chip_select_lines, .stack_overflow, .stack_underflow,
    .stack_pointer_reg, .gpr_addr
  );
  always #2 pclk = ~pclk;
  always @(posedge pclk) if (xtal_run) crystal_input <= ~crystal_input;
  function automatic logic [15:0] cfg_rst(input logic [15:0] s, input logic acc_pin);
    cfg_rst = 16'h0000;
    cfg_rst[B_MEM_EN] = acc_pin;
    cfg_rst[B_BYTE_DIS] = s[S_BUSW];
    cfg_rst[B_WR_CFG] = s[S_WR_CFG];
  endfunction
  task automatic give_verdict();
    $display("mismatches %0d, checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [15:0] i, input logic [15:0] d, input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {16'h0000, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // pready high ends this wait; only the watchdog ends it if pready never rises
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [15:0] i, input logic [15:0] d);
    apb(1'b1, i, d, 4'h3);
  endtask
  task automatic rchk(input string nm, input logic [15:0] i, input logic [15:0] e);
    apb(1'b0, i, 16'h0000, 4'h0);
    `CHK(nm, e, rdat[15:0])
  endtask
  // order: push, pop, soft reset, end of init, powerdown
  task automatic pulse(input int k);
    {stack_push, stack_pop, soft_reset_req, end_of_init_instr, powerdown_instr} <= 5'h01 << k;
    @(posedge pclk);
    {stack_push, stack_pop, soft_reset_req, end_of_init_instr, powerdown_instr} <= 5'h00;
    @(posedge pclk);
  endtask
  task automatic sreset();
    soft_reset_req <= 1'b1;
    @(posedge pclk);
    soft_reset_req <= 1'b0;
    cnt = 0;
    repeat (1100) begin
      @(posedge pclk);
      cnt += int'(rst_pin === 1'b0);
    end
  endtask
  task automatic wait_clk(input int c);
    repeat (c) @(posedge pclk);
  endtask
  initial begin
    #200000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {soft_reset_req, end_of_init_instr, powerdown_instr, ale, stack_push, stack_pop} = '0;
    {fast_ext_irq_pins, gpr_index, cs_decode, crystal_input} = '0;
    {nmi_pin_n, ext_rstn, pll_bypass, xtal_run} = 4'hF;
    seed = 32'hE823CA2E;
    strap_port_zero = 16'($random(seed));
    external_access_pin = 1'($random(seed));
    wait_clk(12);
    presetn <= 1'b1;
    wait_clk(3);
    `CHK("cfg reset", cfg_rst(strap_port_zero, external_access_pin), system_config)
    rchk("cfg word", IDX_SYSCFG, cfg_rst(strap_port_zero, external_access_pin));
    rchk("cfg alias", IDX_SYSCFG_SH, cfg_rst(strap_port_zero, external_access_pin));
    apb(1'b0, 16'h1000, 16'h0000, 4'h0);
    `CHK("unmapped err", 1'b1, rerr)
    for (int k = 0; k < 4; k++) rchk("reset val", IDX_SP + 16'(k), rst_tab[k]);
    repeat (4) begin
      v = 16'($random(seed));
      wr(IDX_SYSCFG, v);
      rchk("cfg rw", IDX_SYSCFG_SH, v);
      `CHK("xbus en", v[B_XBUS_EN], xbus_periph_enable)
    end
    apb(1'b1, IDX_SYSCFG, ~v, 4'h1);
    rchk("cfg lane", IDX_SYSCFG, {v[15:8], ~v[7:0]});
    cs_old = 5'h1F;
    for (int c = 0; c < 2; c++) begin
      wr(IDX_SYSCFG, 16'(c) << B_CS_CFG);
      cs_decode <= cs_old ^ (5'($random(seed)) | 5'h01);
      wait_clk(3);
      ale <= 1'b1;
      wait_clk(2);
      if (c == 1) `CHK("cs unlatched", cs_decode, chip_select_lines)
      else `CHK("cs latched early", cs_old, chip_select_lines)
      wait_clk(1);
      `CHK("chip sel", cs_decode, chip_select_lines)
      cs_old = cs_decode;
      ale <= 1'b0;
    end
    wr(IDX_OVF_LIM, 16'hFBF8);
    sp_e = SP_RST;
    for (int k = 1; k <= 11; k++) begin
      pulse(k <= 5 ? 4 : 3);
      sp_e = k <= 5 ? sp_e - STACK_STEP : sp_e + STACK_STEP;
      `CHK("sp", sp_e, stack_pointer_reg)
      if (k == 4 || k == 5) `CHK("ovf", k == 5, stack_overflow)
      if (k >= 10) `CHK("unf", k == 11, stack_underflow)
    end
    wr(IDX_STATUS, 16'h0003);
    `CHK("flags clr", 2'b00, {stack_overflow, stack_underflow})
    v = 16'($random(seed)) & 16'hFFFE;
    wr(IDX_CTX_PTR, v);
    gpr_index <= 4'($random(seed));
    wait_clk(3);
    `CHK("gpr addr", v + {11'h000, gpr_index, 1'b0}, gpr_addr)
    wr(IDX_SYSCFG, 16'h0001 << B_OSC_WD_DIS);
    wait_clk(3);
    `CHK("pll off", 2'b00, {pll_enable, clk_on_pll})
    wr(IDX_SYSCFG, 16'h0000);
    xtal_run <= 1'b0;
    wait_clk(WD_IDLE_CYC - 10);
    `CHK("owd early", 1'b0, clk_on_pll)
    wait_clk(20);
    `CHK("owd trip", 1'b1, clk_on_pll)
    xtal_run <= 1'b1;
    pulse(0);
    `CHK("pd nmi high", 1'b0, powerdown_active)
    nmi_pin_n <= 1'b0;
    wait_clk(4);
    pulse(0);
    `CHK("pd enter", 1'b1, powerdown_active)
    nmi_pin_n <= 1'b1;
    wait_clk(4);
    `CHK("pd hold", 1'b1, powerdown_active)
    ext_rstn <= 1'b0;
    wait_clk(5);
    `CHK("pd exit", 1'b0, powerdown_active)
    ext_rstn <= 1'b1;
    wr(IDX_IRQEN, 16'h0001);
    wr(IDX_SYSCFG, 16'h0001 << B_PD_CFG);
    for (int k = 1; k <= 3; k++) begin
      fast_ext_irq_pins <= 4'(k);
      wait_clk(4);
      if (k < 3) pulse(0);
      `CHK("pd irq", k == 2, powerdown_active)
    end
    fast_ext_irq_pins <= 4'h0;
    v = 16'($random(seed)) | (16'h0001 << B_BDRST);
    wr(IDX_SYSCFG, v);
    pulse(1);
    wr(IDX_SYSCFG, ~v);
    rchk("locked", IDX_SYSCFG, v);
    `CHK("lock hold", v, system_config)
    rchk("status", IDX_STATUS, {11'h000, 1'b0, !v[B_OSC_WD_DIS], 1'b1, 2'b00});
    sreset();
    `CHK("drive len", 1024, cnt)
    `CHK("cfg again", cfg_rst(strap_port_zero, external_access_pin), system_config)
    sreset();
    `CHK("no drive", 0, cnt)
    give_verdict();
  end
endmodule
`default_nettype wire
